//--- common/rftc_pkg.sv
// Shared constants and types for the RF frame transmit control block
package rftc_pkg;

   // Register offsets
   localparam logic [7:0] FRAME_LEN_OFF = 8'h31;
   localparam logic [7:0] CTRL_OFF = 8'h32;
   localparam logic [7:0] FCOUNT_OFF = 8'h33;
   localparam logic [7:0] STATUS_OFF = 8'h37;
   localparam logic [7:0] BANK_LO_OFF = 8'h38;
   localparam logic [7:0] BANK_HI_OFF = 8'h3B;
   localparam logic [7:0] SPACING_OFF = 8'h3C;
   localparam logic [7:0] BUF_BASE_OFF = 8'h40;
   localparam logic [7:0] BUF_LAST_OFF = 8'h4F;

   // Field positions, transmit_start_page_power
   localparam int SEND_BIT = 7;
   localparam int PAGE_BIT = 6;
   localparam int TAIL_BIT = 5;
   // Field positions, frame_count_and_spacing
   localparam int DATA_BIT = 7;
   localparam int PD_BIT = 6;
   localparam int ISP_BIT = 5;
   localparam int IDLY_BIT = 4;
   // Field positions, status and control
   localparam int CFLAG_BIT = 7;
   localparam int EFLAG_BIT = 6;
   localparam int ACK_BIT = 5;
   localparam int MRST_BIT = 4;
   localparam int MODE_LSB = 2;
   localparam int IEN_BIT = 0;

   // Value after reset, and the direct mode code
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [1:0] MODE_DIRECT = 2'h3;

   // Message tail length in bit times
   localparam logic [1:0] TAIL_BITS = 2'h2;
   // Oscillator restart lead ahead of the next frame, in ms
   localparam logic [7:0] RESTART_MS = 8'h01;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam int BIT_RATE_BPS = 9600;
   localparam int BIT_CYCLES = 1000000000 / (CLK_PERIOD_NS * BIT_RATE_BPS);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ISPACE,
      ST_FRAME,
      ST_TAIL,
      ST_GAP,
      ST_IRQGAP
   } rftc_state_t;

endpackage : rftc_pkg

//--- rtl/rftc_frame_ctrl.sv
// RF frame transmit sequencer with its control registers and data buffer
//
// Behaviour
// - Each frame carries frame length field plus one bits, 2 to 256.
// - Frame length zero sends nothing even when start is requested.
// - Setting start sends the data buffer using the frame length.
// - Start clears itself at the end of data and on module reset; the code holds it through the delayed-flag interval.
// - Writing zero to start aborts the transmission at once.
// - Start reads one while sending, zero otherwise.
// - Page bit maps the sixteen access registers onto low or high buffer half.
// - Page bit also switches the register bank at 38 to 3B.
// - Page bit cleared only by system reset, not module reset.
// - Tail enable appends two data-one bit times after each datagram.
// - Direct mode 11 drives the amplifier from the output-state bit.
// - Power-down bit lets the oscillator sleep during interframe waits.
// - Oscillator restarts 1 ms before the interval ends if a frame follows.
// - Initial-space bit inserts the timed delay before the first frame.
// - Without delay, completion flag sets right after the last frame.
// - With delay, completion flag sets one interval after the last frame; the code flags at once when frame count is zero.
// - Frames per datagram is frame count plus one, spaced by the interval.
// - Control fields reset to zero; module reset clears the listed fields.
// - Five-bit power field selects the transmitter output power level.
// - Writing one to acknowledge clears the flags; enable gates the request.
// - Transmit error turns output off, clears start, sets error flag; the code ignores it while idle, even in direct mode.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module rftc_frame_ctrl #(
   parameter int MS_CYCLES = rftc_pkg::MS_CYCLES,  // Clocks per millisecond
   parameter int BIT_CYCLES = rftc_pkg::BIT_CYCLES // Clocks per bit time
) (
   input wire logic clk,            // System clock, 100 MHz
   input wire logic rst_b,          // System reset, async, active low
   input wire logic [7:0] addr,     // Register address
   input wire logic [7:0] wrData,   // Write data
   input wire logic wrEn,           // Write strobe
   input wire logic rdEn,           // Read strobe
   output logic [7:0] rdData,       // Read data, cycle after strobe
   input wire logic txError,        // Lock or oscillator failure
   output logic rfOut,              // Amplifier data state
   output logic paEnable,           // Amplifier on
   output logic xcoPowerOn,         // Oscillator and analog blocks on
   output logic [4:0] powerStep,    // Output power step
   output logic completionFlag,     // Datagram done flag
   output logic errorFlag,          // Transmit error flag
   output logic irqReq              // Flag gated by enable
);

   typedef struct packed {
      rftc_pkg::rftc_state_t st;
      logic [7:0] frameLen;
      logic tailEn;
      logic page;
      logic [4:0] power;
      logic dataState;
      logic pdEn;
      logic ispEn;
      logic idlyEn;
      logic [3:0] fnum;
      logic irqEn;
      logic [1:0] mode;
      logic [7:0] spacing;
      logic cflag;
      logic eflag;
      logic [7:0] bitCnt;
      logic [3:0] frameCnt;
      logic [7:0] msCnt;
      logic [1:0] tailCnt;
      logic txBit;
      logic paOn;
      logic xcoOn;
      logic [7:0] rdData;
      logic [31:0][7:0] buffer;
      logic [7:0][7:0] bank;
   } rftc_regs_t;

   rftc_regs_t s_r;
   rftc_regs_t s_nxt;

   logic bitTick;
   logic msTick;
   logic bitRestart;
   logic msRestart;
   logic startReq;
   logic abortReq;
   logic modReset;
   logic ack;
   logic dataEnd;
   logic done;
   logic setErr;
   logic active;
   logic [7:0] rdVal;

   // Address decode helpers shared by read and write paths
   function automatic logic is_buf(input logic [7:0] a);
      is_buf = (a >= rftc_pkg::BUF_BASE_OFF) && (a <= rftc_pkg::BUF_LAST_OFF);
   endfunction : is_buf

   function automatic logic is_bank(input logic [7:0] a);
      is_bank = (a >= rftc_pkg::BANK_LO_OFF) && (a <= rftc_pkg::BANK_HI_OFF);
   endfunction : is_bank

   function automatic logic [4:0] buf_idx(input logic pg, input logic [7:0] a);
      buf_idx = {pg, a[3:0]};
   endfunction : buf_idx

   function automatic logic [2:0] bank_idx(input logic pg, input logic [7:0] a);
      bank_idx = {pg, a[1:0]};
   endfunction : bank_idx

   // Bit-time and millisecond enables
   rftc_tick_div #(
      .DIV(BIT_CYCLES)
   ) u_bit_div (
      .clk(clk),
      .rst_b(rst_b),
      .restart(bitRestart),
      .tick(bitTick)
   );

   rftc_tick_div #(
      .DIV(MS_CYCLES)
   ) u_ms_div (
      .clk(clk),
      .rst_b(rst_b),
      .restart(msRestart),
      .tick(msTick)
   );

   assign active = (s_r.st != rftc_pkg::ST_IDLE);

   // Read mux, from current register state
   always_comb begin
      rdVal = 8'h00;
      if (addr == rftc_pkg::FRAME_LEN_OFF) begin
         rdVal = s_r.frameLen;
      end else if (addr == rftc_pkg::CTRL_OFF) begin
         rdVal = {active, s_r.page, s_r.tailEn, s_r.power};
      end else if (addr == rftc_pkg::FCOUNT_OFF) begin
         rdVal = {s_r.dataState, s_r.pdEn, s_r.ispEn, s_r.idlyEn, s_r.fnum};
      end else if (addr == rftc_pkg::STATUS_OFF) begin
         rdVal[rftc_pkg::CFLAG_BIT] = s_r.cflag;
         rdVal[rftc_pkg::EFLAG_BIT] = s_r.eflag;
         rdVal[rftc_pkg::MODE_LSB +: 2] = s_r.mode;
         rdVal[rftc_pkg::IEN_BIT] = s_r.irqEn;
      end else if (addr == rftc_pkg::SPACING_OFF) begin
         rdVal = s_r.spacing;
      end else if (is_bank(addr)) begin
         rdVal = s_r.bank[bank_idx(s_r.page, addr)];
      end else if (is_buf(addr)) begin
         rdVal = s_r.buffer[buf_idx(s_r.page, addr)];
      end
   end

   // Register writes, sequencer and outputs
   always_comb begin
      s_nxt = s_r;
      startReq = 1'b0;
      abortReq = 1'b0;
      modReset = 1'b0;
      ack = 1'b0;
      dataEnd = 1'b0;
      done = 1'b0;
      setErr = 1'b0;

      // Software writes; bank and buffer index use the page before the write
      if (wrEn) begin
         if (addr == rftc_pkg::FRAME_LEN_OFF) begin
            s_nxt.frameLen = wrData;
         end else if (addr == rftc_pkg::CTRL_OFF) begin
            s_nxt.page = wrData[rftc_pkg::PAGE_BIT];
            s_nxt.tailEn = wrData[rftc_pkg::TAIL_BIT];
            s_nxt.power = wrData[4:0];
            startReq = wrData[rftc_pkg::SEND_BIT];
            abortReq = !wrData[rftc_pkg::SEND_BIT];
         end else if (addr == rftc_pkg::FCOUNT_OFF) begin
            s_nxt.dataState = wrData[rftc_pkg::DATA_BIT];
            s_nxt.pdEn = wrData[rftc_pkg::PD_BIT];
            s_nxt.ispEn = wrData[rftc_pkg::ISP_BIT];
            s_nxt.idlyEn = wrData[rftc_pkg::IDLY_BIT];
            s_nxt.fnum = wrData[3:0];
         end else if (addr == rftc_pkg::STATUS_OFF) begin
            s_nxt.irqEn = wrData[rftc_pkg::IEN_BIT];
            s_nxt.mode = wrData[rftc_pkg::MODE_LSB +: 2];
            ack = wrData[rftc_pkg::ACK_BIT];
            modReset = wrData[rftc_pkg::MRST_BIT];
         end else if (addr == rftc_pkg::SPACING_OFF) begin
            s_nxt.spacing = wrData;
         end else if (is_bank(addr)) begin
            s_nxt.bank[bank_idx(s_r.page, addr)] = wrData;
         end else if (is_buf(addr)) begin
            s_nxt.buffer[buf_idx(s_r.page, addr)] = wrData;
         end
      end

      // Frame sequencer
      case (s_r.st)
         rftc_pkg::ST_IDLE: begin
            if (startReq && (s_r.frameLen != 8'h00)) begin
               s_nxt.bitCnt = 8'h00;
               s_nxt.frameCnt = 4'h0;
               if (s_r.ispEn) begin
                  s_nxt.st = rftc_pkg::ST_ISPACE;
                  s_nxt.msCnt = s_r.spacing;
               end else begin
                  s_nxt.st = rftc_pkg::ST_FRAME;
               end
            end
         end
         rftc_pkg::ST_ISPACE: begin
            if (s_r.msCnt == 8'h00) begin
               s_nxt.st = rftc_pkg::ST_FRAME;
               s_nxt.bitCnt = 8'h00;
            end else if (msTick) begin
               s_nxt.msCnt = s_r.msCnt - 8'h01;
            end
         end
         rftc_pkg::ST_FRAME: begin
            if (bitTick) begin
               if (s_r.bitCnt == s_r.frameLen) begin
                  if (s_r.frameCnt == s_r.fnum) begin
                     if (s_r.tailEn) begin
                        s_nxt.st = rftc_pkg::ST_TAIL;
                        s_nxt.tailCnt = 2'h0;
                     end else begin
                        dataEnd = 1'b1;
                     end
                  end else begin
                     s_nxt.st = rftc_pkg::ST_GAP;
                     s_nxt.msCnt = s_r.spacing;
                     s_nxt.frameCnt = s_r.frameCnt + 4'h1;
                  end
               end else begin
                  s_nxt.bitCnt = s_r.bitCnt + 8'h01;
               end
            end
         end
         rftc_pkg::ST_TAIL: begin
            if (bitTick) begin
               if (s_r.tailCnt == (rftc_pkg::TAIL_BITS - 2'h1)) begin
                  dataEnd = 1'b1;
               end else begin
                  s_nxt.tailCnt = s_r.tailCnt + 2'h1;
               end
            end
         end
         rftc_pkg::ST_GAP: begin
            if (s_r.msCnt == 8'h00) begin
               s_nxt.st = rftc_pkg::ST_FRAME;
               s_nxt.bitCnt = 8'h00;
            end else if (msTick) begin
               s_nxt.msCnt = s_r.msCnt - 8'h01;
            end
         end
         rftc_pkg::ST_IRQGAP: begin
            if (s_r.msCnt == 8'h00) begin
               done = 1'b1;
            end else if (msTick) begin
               s_nxt.msCnt = s_r.msCnt - 8'h01;
            end
         end
         default: begin
            s_nxt.st = rftc_pkg::ST_IDLE;
         end
      endcase

      // Last frame finished: flag now, or after one more interval
      if (dataEnd) begin
         if (s_r.idlyEn && (s_r.fnum != 4'h0)) begin
            s_nxt.st = rftc_pkg::ST_IRQGAP;
            s_nxt.msCnt = s_r.spacing;
         end else begin
            done = 1'b1;
         end
      end
      if (done) begin
         s_nxt.st = rftc_pkg::ST_IDLE;
      end

      // Module reset beats an error, which beats an abort
      if (modReset) begin
         s_nxt.st = rftc_pkg::ST_IDLE;
         s_nxt.frameLen = rftc_pkg::REG_RST;
         s_nxt.tailEn = 1'b0;
         s_nxt.pdEn = 1'b0;
         s_nxt.ispEn = 1'b0;
         s_nxt.idlyEn = 1'b0;
         s_nxt.fnum = 4'h0;
         done = 1'b0;
         // Page survives here on purpose; only system reset clears it
         s_nxt.page = s_r.page;
      end else if (txError && active) begin
         s_nxt.st = rftc_pkg::ST_IDLE;
         setErr = 1'b1;
         done = 1'b0;
      end else if (abortReq && active) begin
         s_nxt.st = rftc_pkg::ST_IDLE;
         done = 1'b0;
      end

      // Hardware set wins over a same-cycle acknowledge
      s_nxt.cflag = (s_r.cflag && !ack) || done;
      s_nxt.eflag = (s_r.eflag && !ack) || setErr;

      // Amplifier data: buffer bits MSB first within each byte
      s_nxt.txBit = 1'b0;
      s_nxt.paOn = 1'b0;
      if (s_nxt.st == rftc_pkg::ST_FRAME) begin
         s_nxt.txBit = s_nxt.buffer[s_nxt.bitCnt[7:3]][3'h7 - s_nxt.bitCnt[2:0]];
         s_nxt.paOn = 1'b1;
      end else if (s_nxt.st == rftc_pkg::ST_TAIL) begin
         s_nxt.txBit = 1'b1;
         s_nxt.paOn = 1'b1;
      end else if ((s_nxt.st == rftc_pkg::ST_IDLE) && (s_nxt.mode == rftc_pkg::MODE_DIRECT)) begin
         s_nxt.txBit = s_nxt.dataState;
         s_nxt.paOn = 1'b1;
      end
      if (setErr) begin
         s_nxt.paOn = 1'b0;
         s_nxt.txBit = 1'b0;
      end

      // With power-down set, oscillator sleeps in gap and delayed-flag waits, waking one ms early when a frame follows
      s_nxt.xcoOn = (s_nxt.st != rftc_pkg::ST_IDLE);
      if (s_nxt.pdEn) begin
         if (s_nxt.st == rftc_pkg::ST_GAP) begin
            s_nxt.xcoOn = (s_nxt.msCnt <= rftc_pkg::RESTART_MS);
         end else if (s_nxt.st == rftc_pkg::ST_IRQGAP) begin
            s_nxt.xcoOn = 1'b0;
         end
      end

      // Read data stands for exactly one cycle
      s_nxt.rdData = rdEn ? rdVal : 8'h00;
   end

   // Dividers realign on entry so the first bit or ms is full length
   assign bitRestart = (s_nxt.st == rftc_pkg::ST_FRAME) && (s_r.st != rftc_pkg::ST_FRAME);
   assign msRestart = (s_nxt.st != s_r.st);

   // Whole state registered; all control fields clear on system reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops, request gated by enable
   assign rdData = s_r.rdData;
   assign rfOut = s_r.txBit;
   assign paEnable = s_r.paOn;
   assign xcoPowerOn = s_r.xcoOn;
   assign powerStep = s_r.power;
   assign completionFlag = s_r.cflag;
   assign errorFlag = s_r.eflag;
   assign irqReq = (s_r.cflag || s_r.eflag) && s_r.irqEn;

endmodule : rftc_frame_ctrl

//--- rtl/rftc_tick_div.sv
// Restartable divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
module rftc_tick_div #(
   parameter int DIV = 1000
) (
   input wire logic clk,     // System clock
   input wire logic rst_b,   // Async reset, active low
   input wire logic restart, // Realign the period to now
   output logic tick         // One-cycle enable pulse
);

   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } rftc_div_t;

   rftc_div_t s_r;
   rftc_div_t s_nxt;

   // Count up and wrap; restart gives a full period from here
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (restart) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt == LAST) begin
         s_nxt.cnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

endmodule : rftc_tick_div

//--- tb/rftc_frame_ctrl_asserts.sv
// Port-level checks for the frame transmit control block
`timescale 1ns/1ns
module rftc_frame_ctrl_asserts #(
   parameter int BIT_CYCLES = 4 // Clocks per bit time
) (
   input wire logic clk, // System clock
   input wire logic rst_b, // Reset, active low
   input wire logic [7:0] addr, // Register address
   input wire logic [7:0] wrData, // Write data
   input wire logic wrEn, // Write strobe
   input wire logic rdEn, // Read strobe
   input wire logic [7:0] rdData, // Read data
   input wire logic txError, // Transmit failure
   input wire logic rfOut, // Amplifier data state
   input wire logic paEnable, // Amplifier on
   input wire logic xcoPowerOn, // Oscillator on
   input wire logic [4:0] powerStep, // Power step
   input wire logic completionFlag, // Done flag
   input wire logic errorFlag, // Error flag
   input wire logic irqReq // Gated request
);
   int hiCnt_r; // Cycles the amplifier has been on
   // On-time counter, so a short burst shows at its falling edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) hiCnt_r <= 0;
      else hiCnt_r <= paEnable ? hiCnt_r + 1 : 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_ackWr;
      wrEn && addr == rftc_pkg::STATUS_OFF && wrData[rftc_pkg::ACK_BIT];
   endsequence
   sequence s_ctrlWr;
      wrEn && addr == rftc_pkg::CTRL_OFF;
   endsequence
   property p_rdQuiet;
      !$past(rdEn) |-> rdData == 8'h00;
   endproperty
   property p_pwrSrc;
      s_ctrlWr |=> powerStep == $past(wrData[4:0]);
   endproperty
   property p_ackClr;
      s_ackWr ##0 !txError |=> !errorFlag;
   endproperty
   property p_doneHold;
      $fell(completionFlag) |-> $past(wrEn) && $past(addr) == rftc_pkg::STATUS_OFF
         && $past(wrData[rftc_pkg::ACK_BIT]);
   endproperty
   property p_errStop;
      $rose(errorFlag) |-> $past(txError) && !paEnable;
   endproperty
   property p_irqSrc;
      irqReq |-> completionFlag || errorFlag;
   endproperty
   property p_doneQuiet;
      $rose(completionFlag) |-> !paEnable;
   endproperty
   property p_frameMin;
      $fell(paEnable) && !$past(txError) && !$past(wrEn) |-> hiCnt_r >= 2 * BIT_CYCLES - 1;
   endproperty
   property p_xcoReady;
      $rose(paEnable) && !$past(wrEn) |-> $past(xcoPowerOn);
   endproperty
   a_rdQuiet: assert property (p_rdQuiet) else $error("read data outside read slot");
   a_pwrSrc: assert property (p_pwrSrc) else $error("power step not from write");
   a_ackClr: assert property (p_ackClr) else $error("error flag survived ack");
   a_doneHold: assert property (p_doneHold) else $error("done flag fell without ack");
   a_errStop: assert property (p_errStop) else $error("error flag without stop");
   a_irqSrc: assert property (p_irqSrc) else $error("request without flag");
   a_doneQuiet: assert property (p_doneQuiet) else $error("done flag while sending");
   a_frameMin: assert property (p_frameMin) else $error("burst shorter than two bits");
   a_xcoReady: assert property (p_xcoReady) else $error("frame with oscillator off");
endmodule : rftc_frame_ctrl_asserts

bind rftc_frame_ctrl rftc_frame_ctrl_asserts #(.BIT_CYCLES(BIT_CYCLES)) chk (.clk, .rst_b,
   .addr, .wrData, .wrEn, .rdEn, .rdData, .txError, .rfOut, .paEnable, .xcoPowerOn,
   .powerStep, .completionFlag, .errorFlag, .irqReq);

//--- tb/rftc_rx_model.sv
// Remote receiver model sampling the keyed carrier at mid-bit
`timescale 1ns/1ns
module rftc_rx_model #(
   parameter int BIT_CYCLES = 4 // Clocks per bit time
) (
   input wire logic clk, // System clock
   input wire logic paEnable, // Carrier on
   input wire logic rfOut, // Keyed data state
   input wire logic xcoPowerOn, // Oscillator on
   output int frames, // Bursts seen
   output logic [31:0] bits, // Latest burst, last bit in bit 0
   output int nBits, // Bits in the latest burst
   output int riseAt, // Cycle of latest burst start
   output int fallAt, // Cycle of latest burst end
   output int xcoRun, // Oscillator on-time before latest start
   output int cycle // Free cycle count
);
   int ph = 0;
   int xcoCnt = 0;
   logic paLast = 1'b0;
   initial {frames, bits, nBits, riseAt, fallAt, xcoRun, cycle} = '0;
   // Mid-bit sampling rides out the one-cycle divider alignment
   always @(posedge clk) begin
      cycle++;
      xcoCnt = xcoPowerOn ? xcoCnt + 1 : 0;
      if (paEnable && !paLast) begin
         frames++;
         bits = '0;
         nBits = 0;
         ph = 0;
         riseAt = cycle;
         xcoRun = xcoCnt;
      end
      if (paEnable) begin
         if (ph % BIT_CYCLES == BIT_CYCLES / 2) begin
            bits = {bits[30:0], rfOut};
            nBits++;
         end
         ph++;
      end
      if (!paEnable && paLast) fallAt = cycle;
      paLast = paEnable;
   end
endmodule : rftc_rx_model

//--- tb/tb_top.sv
// Self-checking bench for the frame transmit control block
`timescale 1ns/1ns
module tb_top;
   localparam int MS = 20;
   localparam int BC = 4;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic txError = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wrData = 8'h00;
   logic [7:0] rdData, v, len, cfg, pw;
   logic rfOut, paEnable, xcoPowerOn, completionFlag, errorFlag, irqReq;
   logic [4:0] powerStep;
   logic [31:0] bits, seed = 32'h746E;
   logic [7:0] mem [34];
   logic [7:0] regs [6] = '{8'h31, 8'h32, 8'h33, 8'h37, 8'h3C, 8'h30};
   int miscompares = 0;
   int checks_done = 0;
   int frames, nBits, riseAt, fallAt, xcoRun, cycle, f0, t0;

   rftc_frame_ctrl #(.MS_CYCLES(MS), .BIT_CYCLES(BC)) dut (.clk, .rst_b, .addr, .wrData,
      .wrEn, .rdEn, .rdData, .txError, .rfOut, .paEnable, .xcoPowerOn, .powerStep,
      .completionFlag, .errorFlag, .irqReq);
   rftc_rx_model #(.BIT_CYCLES(BC)) rx (.clk, .paEnable, .rfOut, .xcoPowerOn, .frames,
      .bits, .nBits, .riseAt, .fallAt, .xcoRun, .cycle);

   // Free-running 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   // Watchdog sized well past the expected run
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      results();
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // First len+1 bits of bytes 0 and 1, sent MSB first
   function automatic logic [31:0] expBits(logic [7:0] n);
      return {16'h0000, mem[0], mem[1]} >> (15 - n);
   endfunction : expBits
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      wrEn <= 1'b1;
      addr <= a;
      wrData <= d;
      @(posedge clk);
      wrEn <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rdEn <= 1'b1;
      addr <= a;
      @(posedge clk);
      rdEn <= 1'b0;
      #1;
      d = rdData;
   endtask : rd
   // Start a datagram, wait for the flag, check what the receiver got
   task automatic datagram(logic [7:0] n, logic [7:0] c, logic [7:0] tl);
      int k;
      f0 = frames;
      k = 0;
      wr(8'h31, n);
      wr(8'h33, c);
      wr(8'h32, 8'h80 | tl);
      t0 = cycle;
      rd(8'h32, v);
      chk("busy", v[7], 1'b1);
      while (completionFlag !== 1'b1 && k < 3000) begin
         tick(1);
         k++;
      end
      chk("done seen", k < 3000, 1'b1);
      chk("frames", frames - f0, c[3:0] + 1);
      chk("bit count", nBits, n + 1 + (tl != 0 ? 2 : 0));
      chk("data", bits >> (tl != 0 ? 2 : 0), expBits(n));
      chk("irq", irqReq, 1'b1);
      rd(8'h32, v);
      chk("ended", v[7], 1'b0);
   endtask : datagram
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      foreach (regs[i]) begin
         rd(regs[i], v);
         chk("reset value", v, 8'h00);
      end
      // Both buffer halves and both banks, then read back
      for (int p = 0; p < 2; p++) begin
         wr(8'h32, p[0] ? 8'h40 : 8'h00);
         for (int i = 0; i < 17; i++) begin
            mem[i < 16 ? p * 16 + i : 32 + p] = 8'(xs());
            wr(i < 16 ? 8'(8'h40 + i) : 8'h38, mem[i < 16 ? p * 16 + i : 32 + p]);
         end
      end
      for (int p = 0; p < 2; p++) begin
         wr(8'h32, p[0] ? 8'h40 : 8'h00);
         for (int i = 0; i < 17; i++) begin
            rd(i < 16 ? 8'(8'h40 + i) : 8'h38, v);
            chk("buffer page", v, mem[i < 16 ? p * 16 + i : 32 + p]);
         end
      end
      $display("buffer test done");
      // Module reset keeps page and power, clears the frame fields
      pw = 8'(xs() % 32);
      wr(8'h32, 8'h40 | pw);
      wr(8'h31, 8'h55);
      wr(8'h33, 8'hFF);
      wr(8'h37, 8'h10);
      rd(8'h32, v);
      chk("page kept", v, 8'h40 | pw);
      chk("power", powerStep, pw);
      rd(8'h31, v);
      chk("length cleared", v, 8'h00);
      rd(8'h33, v);
      chk("fields cleared", v, 8'h80);
      $display("module reset test done");
      wr(8'h32, 8'h00);
      wr(8'h37, 8'h01);
      wr(8'h3C, 8'h02);
      // Random datagrams, no options
      for (int k = 0; k < 3; k++) begin
         len = 8'(xs() % 15 + 1);
         cfg = 8'(xs() % 3);
         datagram(len, cfg, 8'h00);
         chk("prompt flag", cycle - fallAt <= 3, 1'b1);
         if (cfg != 0) chk("xco held", xcoRun > 2 * MS, 1'b1);
         wr(8'h37, 8'h21);
         chk("ack", {completionFlag, irqReq}, 2'b00);
      end
      // Tail, then delay-select ignored for a single frame
      datagram(8'h01, 8'h00, 8'h20);
      chk("tail ones", bits[1:0], 2'b11);
      wr(8'h37, 8'h21);
      datagram(8'h05, 8'h10, 8'h00);
      chk("single last", cycle - fallAt <= 3, 1'b1);
      wr(8'h37, 8'h21);
      wr(8'h3C, 8'h03);
      datagram(8'h02, 8'h20, 8'h00);
      chk("initial space", riseAt - t0 >= 3 * MS - 2, 1'b1);
      wr(8'h37, 8'h21);
      datagram(8'h03, 8'h51, 8'h00);
      chk("restart lead", xcoRun >= MS - 3 && xcoRun <= MS + 3, 1'b1);
      chk("delayed flag", cycle - fallAt >= 3 * MS - 2, 1'b1);
      wr(8'h37, 8'h21);
      $display("datagram tests done");
      // Zero length refused, then abort, then error
      f0 = frames;
      wr(8'h31, 8'h00);
      wr(8'h32, 8'h80);
      rd(8'h32, v);
      tick(50);
      chk("zero length", {v[7], frames != f0, completionFlag}, 3'b000);
      wr(8'h31, 8'hFF);
      wr(8'h32, 8'h80);
      tick(20);
      wr(8'h32, 8'h00);
      tick(2);
      rd(8'h32, v);
      chk("abort", {v[7], paEnable, completionFlag}, 3'b000);
      wr(8'h32, 8'h80);
      tick(10);
      @(posedge clk);
      txError <= 1'b1;
      @(posedge clk);
      txError <= 1'b0;
      tick(2);
      rd(8'h32, v);
      chk("error", {v[7], paEnable, errorFlag, irqReq}, 4'b0011);
      wr(8'h37, 8'h21);
      chk("error ack", errorFlag, 1'b0);
      $display("abort and error tests done");
      // Direct drive of the amplifier
      wr(8'h37, 8'h0D);
      for (int d = 1; d >= 0; d--) begin
         wr(8'h33, d[0] ? 8'h80 : 8'h00);
         tick(2);
         chk("direct", {paEnable, rfOut}, {1'b1, d[0]});
      end
      wr(8'h37, 8'h01);
      $display("direct test done");
      results();
   end
endmodule : tb_top
